// ==== core/flash_seq.sv ====
// Purpose: Device-side command sequencer of a serial flash on a four-wire link.
// Assumes: cs_n_i and sck_i are synchronous to clk_i and sck runs at most clk/4.
// Notes: The array, page latch and protection bits sit outside this block.
// Functional notes
// - Dual read: opcode on lane zero, then address and dummy on both lanes.
// - Dual read address moves two bits per clock, odd bits on lane one.
// - Both lane bits caught on one rising edge; dummy values ignored.
// - Dual output: lane one carries bits 7,5,3,1; lane zero 6,4,2,0.
// - Read output runs on with address wrap until chip select rises.
// - Program: opcode 02, 24-bit address, one or more data bytes.
// - Program and erase aimed at a protected area are ignored.
// - Array erase is ignored when any protection is set.
// - Beyond 256 data bytes only the last 256 are kept.
// - Program data wrap inside the target 256-byte page.
// - Program and erase are self-timed; busy shows progress.
// - Dual program: opcode A2, three address bytes, data on two lanes.
// - Dual program runs only if chip select rises on a byte boundary.
// - Opcode 20 erases the 4 KByte sector picked by bits 12 and up.
// - Opcode 52 erases the 32 KByte block picked by bits 15 and up.
// - Opcode D8 erases the 64 KByte block picked by the upper bits.
// - Opcode 60 or C7 erases the whole array.
// - Program and erase start only when chip select rises.
// - Security read: opcode 88, one address byte, one dummy byte.
// - Security data leave on falling edges from the given address.
// - Security output wraps to address zero and runs until chip select rises.
// - Write latch set command sets the write enable latch.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 23,
  parameter int SECID_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic serial_lane_zero_i,
  input wire logic serial_lane_one_i,
  output logic serial_lane_zero_o,
  output logic serial_lane_one_o,
  output logic serial_lane_zero_oe_o,
  output logic serial_lane_one_oe_o,
  input wire logic [3:0] protect_bits_i,
  output logic mem_rd_o,
  output logic secid_sel_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_rdata_i,
  output logic latch_clr_o,
  output logic latch_wr_o,
  output logic [15:0] latch_word_o,
  input wire logic latch_ready_i,
  output logic op_start_o,
  output op_kind_t op_kind_o,
  output logic [ADDR_W-1:0] op_addr_o,
  input wire logic op_done_i,
  output logic busy_o,
  output logic write_enable_latch_o
);
  seq_state_t state;
  cmd_t cmd;
  logic [4:0] cnt;
  logic [4:0] ocnt;
  logic [23:0] in_sr;
  logic [23:0] nsh;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] ptr_inc;
  logic [ADDR_W-1:0] new_addr;
  logic [7:0] pre;
  logic [7:0] out_sr;
  logic [7:0] col;
  logic [4:0] addr_last;
  logic sck_q, rise, fall, rd_q, got_byte, lost;
  logic dual_in, addr_done, dummy_done, byte_done, load_out, push;
  logic is_prog, is_read, prog_ok, erase_ok, take, we_latch_set;
  logic fifo_ready, fifo_empty;

  function automatic cmd_t decode(input logic [7:0] b);
    case (b)
      `OPC_DUAL_READ: decode = CMD_DREAD;
      `OPC_PROG: decode = CMD_PROG;
      `OPC_DUAL_PROG: decode = CMD_DPROG;
      `OPC_SECT_ERASE: decode = CMD_SECT;
      `OPC_BLK32_ERASE: decode = CMD_BLK32;
      `OPC_BLK64_ERASE: decode = CMD_BLK64;
      `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B: decode = CMD_CHIP;
      `OPC_SECID_READ: decode = CMD_SECID;
      `OPC_WRITE_LATCH_SET: decode = CMD_LATCH_SET;
      default: decode = CMD_NONE;
    endcase
  endfunction

  // Protection covers the top 2^(code-1) 64 KByte blocks; code 8 and up covers all.
  function automatic logic area_prot(input logic [3:0] bp, input logic [ADDR_W-1:0] a);
    logic [7:0] n;
    n = (bp >= `PROT_ALL_CODE) ? `TOP_BLOCKS : (8'h01 << (bp - 4'h1));
    area_prot = (bp != 4'h0) &&
      ({1'b0, a[ADDR_W-1:`BLK64_LSB]} >= (`TOP_BLOCKS - n));
  endfunction

  assign rise = sck_i && !sck_q;
  assign fall = !sck_i && sck_q;
  assign is_prog = (cmd == CMD_PROG) || (cmd == CMD_DPROG);
  assign is_read = (cmd == CMD_DREAD) || (cmd == CMD_SECID);
  assign dual_in = ((state == ST_ADDR) && (cmd == CMD_DREAD)) ||
    ((state == ST_DATA) && (cmd == CMD_DPROG));
  assign nsh = dual_in ? {in_sr[21:0], serial_lane_one_i, serial_lane_zero_i} :
    {in_sr[22:0], serial_lane_zero_i};
  assign addr_last = (cmd == CMD_DREAD) ? `ADDR_LAST_DUAL :
    (cmd == CMD_SECID) ? `ADDR_LAST_SECID : `ADDR_LAST_SINGLE;
  assign addr_done = rise && (state == ST_ADDR) && (cnt == addr_last);
  assign dummy_done = rise && (state == ST_DUMMY) &&
    (cnt == ((cmd == CMD_DREAD) ? `DUMMY_LAST_DUAL : `DUMMY_LAST_SECID));
  assign byte_done = rise && (state == ST_DATA) &&
    (cnt == ((cmd == CMD_DPROG) ? `PAIR_LAST : `BIT_LAST));
  assign push = byte_done && is_prog;
  assign load_out = dummy_done || (fall && (state == ST_OUT) &&
    (ocnt == ((cmd == CMD_DREAD) ? `PAIR_LAST : `BIT_LAST)));
  assign new_addr = (cmd == CMD_SECID) ? ADDR_W'(nsh[SECID_W-1:0]) : nsh[ADDR_W-1:0];
  assign ptr_inc = (cmd == CMD_SECID) ? ADDR_W'(SECID_W'(ptr + 1'b1)) :
    ptr + 1'b1;
  assign prog_ok = is_prog && (state == ST_DATA) && (cnt == 5'h00) &&
    got_byte && !lost && !area_prot(protect_bits_i, ptr);
  assign erase_ok = ((state == ST_SKIP) && ((cmd == CMD_SECT) || (cmd == CMD_BLK32) ||
    (cmd == CMD_BLK64)) && !area_prot(protect_bits_i, ptr)) ||
    ((state == ST_SKIP) && (cmd == CMD_CHIP) && (protect_bits_i == 4'h0));
  assign take = cs_n_i && (prog_ok || erase_ok) && write_enable_latch_o && !busy_o;
  assign we_latch_set = cs_n_i && (state == ST_SKIP) && (cmd == CMD_LATCH_SET);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sck_q <= 1'b0;
    else
      sck_q <= sck_i;
  end

  // Command framing: opcode, address, dummy and data phases.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      cmd <= CMD_NONE;
      cnt <= 5'h00;
      in_sr <= 24'h00_0000;
    end
    else if (state == ST_COMMIT)
    begin
      if (fifo_empty)
        state <= ST_IDLE;
    end
    else if (cs_n_i)
      state <= take ? ST_COMMIT : ST_IDLE;
    else if (state == ST_IDLE)
    begin
      state <= ST_OPC;
      cnt <= 5'h00;
    end
    else if (rise)
    begin
      case (state)
        ST_OPC:
        begin
          in_sr <= nsh;
          cnt <= (cnt == `OPC_LAST_CLK) ? 5'h00 : cnt + 5'h01;
          if (cnt == `OPC_LAST_CLK)
          begin
            cmd <= decode(nsh[7:0]);
            state <= (decode(nsh[7:0]) inside {CMD_NONE, CMD_CHIP, CMD_LATCH_SET}) ?
              ST_SKIP : ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          in_sr <= nsh;
          cnt <= addr_done ? 5'h00 : cnt + 5'h01;
          if (addr_done)
            state <= is_read ? ST_DUMMY : is_prog ? ST_DATA : ST_SKIP;
        end
        ST_DUMMY:
        begin
          cnt <= dummy_done ? 5'h00 : cnt + 5'h01;
          if (dummy_done)
            state <= ST_OUT;
        end
        ST_DATA:
        begin
          in_sr <= nsh;
          cnt <= byte_done ? 5'h00 : cnt + 5'h01;
        end
        default:
          state <= state;
      endcase
    end
  end

  // Read pointer and array fetches; data return one cycle after mem_rd_o.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ptr <= '0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= '0;
      secid_sel_o <= 1'b0;
      rd_q <= 1'b0;
      pre <= 8'h00;
    end
    else
    begin
      rd_q <= mem_rd_o;
      if (rd_q)
        pre <= mem_rdata_i;
      mem_rd_o <= 1'b0;
      if (addr_done)
      begin
        ptr <= new_addr;
        mem_rd_o <= is_read;
        mem_addr_o <= new_addr;
        secid_sel_o <= (cmd == CMD_SECID);
      end
      else if (load_out)
      begin
        ptr <= ptr_inc;
        mem_rd_o <= 1'b1;
        mem_addr_o <= ptr_inc;
      end
    end
  end

  // Output shifting on falling clock edges; lanes are released when chip select rises.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cs_n_i)
    begin
      serial_lane_zero_o <= 1'b0;
      serial_lane_one_o <= 1'b0;
      serial_lane_zero_oe_o <= 1'b0;
      serial_lane_one_oe_o <= 1'b0;
      out_sr <= 8'h00;
      ocnt <= 5'h00;
    end
    else if (dummy_done)
    begin
      out_sr <= pre;
      ocnt <= 5'h00;
    end
    else if (fall && (state == ST_OUT))
    begin
      serial_lane_one_o <= out_sr[7];
      serial_lane_one_oe_o <= 1'b1;
      if (cmd == CMD_DREAD)
      begin
        serial_lane_zero_o <= out_sr[6];
        serial_lane_zero_oe_o <= 1'b1;
        out_sr <= {out_sr[5:0], 2'b00};
      end
      else
        out_sr <= {out_sr[6:0], 1'b0};
      ocnt <= ocnt + 5'h01;
      if (load_out)
      begin
        out_sr <= pre;
        ocnt <= 5'h00;
      end
    end
  end

  // Page column tracking; the column wraps so later bytes overwrite earlier ones.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      col <= 8'h00;
      got_byte <= 1'b0;
      lost <= 1'b0;
      latch_clr_o <= 1'b0;
    end
    else
    begin
      latch_clr_o <= addr_done && is_prog;
      if (addr_done)
      begin
        col <= nsh[7:0];
        got_byte <= 1'b0;
        lost <= 1'b0;
      end
      else if (push)
      begin
        col <= col + 8'h01;
        got_byte <= 1'b1;
        if (!fifo_ready)
          lost <= 1'b1;
      end
    end
  end

  byte_fifo #(
    .W(16),
    .D(16),
    .AW(4)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_data_i({col, nsh[7:0]}),
    .in_ready_o(fifo_ready),
    .out_valid_o(latch_wr_o),
    .out_data_o(latch_word_o),
    .out_ready_i(latch_ready_i),
    .empty_o(fifo_empty)
  );

  // Operation launch once all data reached the page latch.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      op_start_o <= 1'b0;
      op_kind_o <= OP_PROG;
      op_addr_o <= '0;
    end
    else
    begin
      op_start_o <= (state == ST_COMMIT) && fifo_empty;
      if (take)
      begin
        case (cmd)
          CMD_SECT:
          begin
            op_kind_o <= OP_SECT;
            op_addr_o <= {ptr[ADDR_W-1:`SECTOR_LSB], `SECTOR_LSB'(0)};
          end
          CMD_BLK32:
          begin
            op_kind_o <= OP_BLK32;
            op_addr_o <= {ptr[ADDR_W-1:`BLK32_LSB], `BLK32_LSB'(0)};
          end
          CMD_BLK64:
          begin
            op_kind_o <= OP_BLK64;
            op_addr_o <= {ptr[ADDR_W-1:`BLK64_LSB], `BLK64_LSB'(0)};
          end
          CMD_CHIP:
          begin
            op_kind_o <= OP_CHIP;
            op_addr_o <= '0;
          end
          default:
          begin
            op_kind_o <= OP_PROG;
            op_addr_o <= ptr;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      busy_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
    end
    else if (busy_o && op_done_i)
    begin
      busy_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
    end
    else if (take)
      busy_o <= 1'b1;
    else if (we_latch_set)
      write_enable_latch_o <= 1'b1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_stop_on_cs;
    cs_n_i |=> !serial_lane_zero_oe_o && !serial_lane_one_oe_o;
  endproperty
  a_stop_on_cs: assert property (p_stop_on_cs) else $error("lanes driven after cs");
  property p_dual_pair;
    fall && !cs_n_i && (state == ST_OUT) && (cmd == CMD_DREAD) |=>
      serial_lane_one_o == $past(out_sr[7]) && serial_lane_zero_o == $past(out_sr[6]);
  endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("dual bit order");
  property p_secid_wrap;
    load_out && (cmd == CMD_SECID) |=> mem_rd_o && (mem_addr_o < (ADDR_W'(1) << SECID_W));
  endproperty
  a_secid_wrap: assert property (p_secid_wrap) else $error("security pointer left space");
  property p_col;
    push |=> col == $past(col) + 8'h01;
  endproperty
  a_col: assert property (p_col) else $error("page column not advanced");
  property p_prog_whole;
    cs_n_i && !busy_o && is_prog && (state == ST_DATA) && (cnt != 5'h00) |=> !busy_o;
  endproperty
  a_prog_whole: assert property (p_prog_whole) else $error("partial byte run");
  property p_sect_mask;
    op_start_o && (op_kind_o == OP_SECT) |-> op_addr_o[11:0] == 12'h000;
  endproperty
  a_sect_mask: assert property (p_sect_mask) else $error("sector low bits set");
  property p_busy_done;
    busy_o && op_done_i |=> !busy_o && !write_enable_latch_o;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy not cleared");
  property p_start_wel;
    op_start_o |-> busy_o && write_enable_latch_o && $past(state == ST_COMMIT);
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("start without latch");
  property p_latch_set;
    we_latch_set && !busy_o |=> write_enable_latch_o;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");
  property p_chip_prot;
    cs_n_i && !busy_o && (state == ST_SKIP) && (cmd == CMD_CHIP) &&
      (protect_bits_i != 4'h0) |=> !busy_o [*2];
  endproperty
  a_chip_prot: assert property (p_chip_prot) else $error("protected erase ran");
  c_dual_read: cover property ((state == ST_OUT) && (cmd == CMD_DREAD) ##1 load_out);
  c_prog: cover property (op_start_o && (op_kind_o == OP_PROG));
  c_chip: cover property (op_start_o && (op_kind_o == OP_CHIP));
endmodule

// ==== core/flash_seq_regs.svh ====
// Purpose: Opcodes, bit counts and field positions of the flash command sequencer.
// Assumes: Included by the sequencer only.
// Notes: Definitions only.
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
`define OPC_DUAL_READ 8'hBB
`define OPC_PROG 8'h02
`define OPC_DUAL_PROG 8'hA2
`define OPC_SECT_ERASE 8'h20
`define OPC_BLK32_ERASE 8'h52
`define OPC_BLK64_ERASE 8'hD8
`define OPC_CHIP_ERASE_A 8'h60
`define OPC_CHIP_ERASE_B 8'hC7
`define OPC_SECID_READ 8'h88
`define OPC_WRITE_LATCH_SET 8'h06
`define OPC_LAST_CLK 5'h07
`define ADDR_LAST_SINGLE 5'h17
`define ADDR_LAST_DUAL 5'h0B
`define ADDR_LAST_SECID 5'h07
`define DUMMY_LAST_DUAL 5'h03
`define DUMMY_LAST_SECID 5'h07
`define PAIR_LAST 5'h03
`define BIT_LAST 5'h07
`define SECTOR_LSB 12
`define BLK32_LSB 15
`define BLK64_LSB 16
`define TOP_BLOCKS 8'h80
`define PROT_ALL_CODE 4'h8
`endif

// ==== core/flash_seq_pkg.sv ====
// Purpose: Types shared by the flash command sequencer.
// Assumes: Nothing beyond the tool's SystemVerilog support.
// Notes: State codes are one-hot.
package flash_seq_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_OPC = 8'h02, ST_ADDR = 8'h04, ST_DUMMY = 8'h08,
    ST_OUT = 8'h10, ST_DATA = 8'h20, ST_SKIP = 8'h40, ST_COMMIT = 8'h80
  } seq_state_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_DREAD = 4'h1, CMD_PROG = 4'h2, CMD_DPROG = 4'h3,
    CMD_SECT = 4'h4, CMD_BLK32 = 4'h5, CMD_BLK64 = 4'h6, CMD_CHIP = 4'h7,
    CMD_SECID = 4'h8, CMD_LATCH_SET = 4'h9
  } cmd_t;
  typedef enum logic [2:0] {
    OP_PROG = 3'h0, OP_SECT = 3'h1, OP_BLK32 = 3'h2, OP_BLK64 = 3'h3, OP_CHIP = 3'h4
  } op_kind_t;
endpackage

// ==== core/byte_fifo.sv ====
// Purpose: Small FIFO with registered output for the program data stream.
// Assumes: One clock, synchronous active-low reset.
// Notes: Read data leave from a register; in_ready_o is low when full.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 16,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic empty_o
);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready_o = (cnt != FULL);
  assign push = in_valid_i && in_ready_o;
  assign pop = (cnt != '0) && (!out_valid_o || out_ready_i);
  assign empty_o = (cnt == '0) && !out_valid_o;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (pop)
    begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end
    else if (out_ready_i)
      out_valid_o <= 1'b0;
  end
endmodule

// ==== sim/spi_host_model.sv ====
// Purpose: Host side of the four-wire link: select, serial clock and both lanes.
// Assumes: Tasks are called from the bench; one bit or pair takes four clk_i cycles.
// Notes: The serial clock idles low and stands still outside frames.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic lane_zero_o,
  output logic lane_one_o,
  output logic lane_oe_o,
  input wire logic lane_zero_i,
  input wire logic lane_one_i
);
  logic [1:0] got;
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    lane_zero_o = 1'b0;
    lane_one_o = 1'b0;
    lane_oe_o = 1'b0;
    got = 2'b00;
  end
  task automatic frame_begin();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    lane_oe_o <= 1'b1;
  endtask
  // Lanes change with the falling clock and are read back after the rise.
  task automatic pair(input logic b1, input logic b0, input logic drv);
    @(posedge clk_i);
    sck_o <= 1'b0;
    lane_one_o <= b1;
    lane_zero_o <= b0;
    lane_oe_o <= drv;
    @(posedge clk_i);
    @(posedge clk_i);
    sck_o <= 1'b1;
    @(posedge clk_i);
    got = {lane_one_i, lane_zero_i};
  endtask
  task automatic byte1(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      pair(~v[i], v[i], 1'b1);
  endtask
  task automatic byte2(input logic [7:0] v);
    for (int i = 3; i >= 0; i--)
      pair(v[2*i+1], v[2*i], 1'b1);
  endtask
  task automatic addr1(input logic [23:0] a);
    byte1(a[23:16]);
    byte1(a[15:8]);
    byte1(a[7:0]);
  endtask
  task automatic addr2(input logic [23:0] a);
    for (int i = 11; i >= 0; i--)
      pair(a[2*i+1], a[2*i], 1'b1);
  endtask
  task automatic rbyte2(output logic [7:0] v);
    for (int i = 3; i >= 0; i--)
    begin
      pair(1'b0, 1'b0, 1'b0);
      v[2*i+1] = got[1];
      v[2*i] = got[0];
    end
  endtask
  task automatic rbyte1(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      pair(1'b0, 1'b0, 1'b0);
      v[i] = got[1];
    end
  endtask
  task automatic frame_end();
    @(posedge clk_i);
    sck_o <= 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    lane_oe_o <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask
endmodule

// ==== sim/serial_flash_dual_read_program_erase_tb_top.sv ====
// Purpose: Self-checking bench of the flash command sequencer.
// Assumes: Array, page latch and self-timed engine are modelled here.
// Notes: Erase commands run from a table; the rest are hand-written cases.
`timescale 1ns/1ps
module serial_flash_dual_read_program_erase_tb_top;
  import flash_seq_pkg::*;
  typedef struct {
    logic [7:0] opc;
    logic [23:0] adr;
    logic has_adr;
    op_kind_t kind;
    logic [22:0] oadr;
  } erase_row_t;
  erase_row_t rows[5] = '{
    '{8'h20, 24'h12_3456, 1'b1, OP_SECT, 23'h12_3000},
    '{8'h52, 24'h12_BFFF, 1'b1, OP_BLK32, 23'h12_8000},
    '{8'hD8, 24'h8F_FFFF, 1'b1, OP_BLK64, 23'h0F_0000},
    '{8'h60, 24'h00_0000, 1'b0, OP_CHIP, 23'h00_0000},
    '{8'hC7, 24'h00_0000, 1'b0, OP_CHIP, 23'h00_0000}};
  logic [15:0] pw[3] = '{16'hFEA5, 16'hFF5A, 16'h003C};
  logic clk_i = 1'b0;
  logic rst_n_i;
  logic cs_n, sck, h_zero, h_one, h_oe, lz, lo, d_zero, d_one, d_oe0, d_oe1;
  logic lz_last, lo_last, latch_ready, op_done;
  logic mem_rd, secid_sel, latch_clr, latch_wr, op_start, busy, we_latch;
  logic [3:0] protect;
  logic [7:0] mem_rdata, rd;
  logic [22:0] mem_addr, op_addr, last_addr;
  logic [15:0] latch_word;
  logic [15:0] lw[$];
  op_kind_t op_kind, last_kind;
  int n_ops = 0, n_clr = 0, op_cnt = 0, n_fail = 0, compares = 0;
  always #20 clk_i = ~clk_i;
  assign lz = d_oe0 ? d_zero : (h_oe ? h_zero : ~lz_last);
  assign lo = d_oe1 ? d_one : (h_oe ? h_one : ~lo_last);
  spi_host_model i_host (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .lane_zero_o(h_zero),
    .lane_one_o(h_one), .lane_oe_o(h_oe), .lane_zero_i(lz), .lane_one_i(lo));
  flash_seq i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck),
    .serial_lane_zero_i(lz), .serial_lane_one_i(lo), .serial_lane_zero_o(d_zero),
    .serial_lane_one_o(d_one), .serial_lane_zero_oe_o(d_oe0), .serial_lane_one_oe_o(d_oe1),
    .protect_bits_i(protect), .mem_rd_o(mem_rd), .secid_sel_o(secid_sel),
    .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata), .latch_clr_o(latch_clr),
    .latch_wr_o(latch_wr), .latch_word_o(latch_word),
    .latch_ready_i(latch_ready), .op_start_o(op_start), .op_kind_o(op_kind),
    .op_addr_o(op_addr), .op_done_i(op_done), .busy_o(busy), .write_enable_latch_o(we_latch));
  function automatic logic [7:0] mdat(input logic [22:0] a, input logic s);
    return s ? {3'b011, a[4:0]} : a[7:0] + a[22:15];
  endfunction
  // Array, stalling page latch and a self-timed engine that finishes after 60 cycles,
  // long enough that busy still stands when a frame's closing wait is over.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lz_last <= 1'b0;
      lo_last <= 1'b0;
      mem_rdata <= 8'h00;
      latch_ready <= 1'b0;
      op_done <= 1'b0;
      op_cnt <= 0;
    end
    else
    begin
      lz_last <= lz;
      lo_last <= lo;
      if (mem_rd)
        mem_rdata <= mdat(mem_addr, secid_sel);
      latch_ready <= ~latch_ready;
      if (latch_wr && latch_ready)
        lw.push_back(latch_word);
      if (latch_clr)
        n_clr <= n_clr + 1;
      op_done <= 1'b0;
      if (op_start)
      begin
        n_ops <= n_ops + 1;
        last_kind <= op_kind;
        last_addr <= op_addr;
        op_cnt <= 60;
      end
      else if (op_cnt != 0)
      begin
        op_cnt <= op_cnt - 1;
        op_done <= (op_cnt == 1);
      end
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_ops(input int k);
    for (int i = 0; i < 3000 && n_ops < k; i++)
      @(posedge clk_i);
    check("op count", n_ops, k);
    if (n_ops < k)
      results();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clk_i);
    check("busy_o", busy, 0);
    check("write_enable_latch_o", we_latch, 0);
    if (busy !== 1'b0)
      results();
  endtask
  task automatic set_we_latch();
    i_host.frame_begin();
    i_host.byte1(8'h06);
    i_host.frame_end();
    check("write_enable_latch_o", we_latch, 1);
  endtask
  task automatic refused(input logic [7:0] opc, input logic [23:0] a, input int k);
    i_host.frame_begin();
    i_host.byte1(opc);
    i_host.addr1(a);
    i_host.byte1(8'h55);
    i_host.frame_end();
    repeat (100) @(posedge clk_i);
    check("op count", n_ops, k);
  endtask
  initial
  begin
    rst_n_i <= 1'b0;
    protect <= 4'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    check("busy_o", busy, 0);
    check("serial_lane_one_oe_o", d_oe1, 0);
    refused(8'h02, 24'h00_0000, 0);
    foreach (rows[r])
    begin
      set_we_latch();
      i_host.frame_begin();
      i_host.byte1(rows[r].opc);
      if (rows[r].has_adr)
        i_host.addr1(rows[r].adr);
      check("op count", n_ops, r);
      i_host.frame_end();
      wait_ops(r + 1);
      check("busy_o", busy, 1);
      check("op_kind_o", last_kind, rows[r].kind);
      if (rows[r].has_adr)
        check("op_addr_o", last_addr, rows[r].oadr);
      wait_idle();
    end
    protect <= 4'h1;
    set_we_latch();
    refused(8'h20, 24'h7F_1000, 5);
    i_host.frame_begin();
    i_host.byte1(8'h60);
    i_host.frame_end();
    repeat (100) @(posedge clk_i);
    check("op count", n_ops, 5);
    protect <= 4'h0;
    set_we_latch();
    lw.delete();
    i_host.frame_begin();
    i_host.byte1(8'h02);
    i_host.addr1(24'h0F_00FE);
    foreach (pw[k])
      i_host.byte1(pw[k][7:0]);
    i_host.frame_end();
    wait_ops(6);
    check("op_kind_o", last_kind, OP_PROG);
    check("op_addr_o page", last_addr[22:8], 15'h0F00);
    check("latch words", lw.size(), 3);
    check("latch_clr_o pulses", n_clr, 2);
    foreach (pw[k])
      check("latch_word_o", lw[k], pw[k]);
    wait_idle();
    set_we_latch();
    lw.delete();
    i_host.frame_begin();
    i_host.byte1(8'hA2);
    i_host.addr1(24'h0F_0010);
    i_host.byte2(8'hC6);
    i_host.frame_end();
    wait_ops(7);
    check("latch_word_o", lw[0], 16'h10C6);
    wait_idle();
    set_we_latch();
    i_host.frame_begin();
    i_host.byte1(8'hA2);
    i_host.addr1(24'h0F_0020);
    i_host.byte2(8'h11);
    i_host.pair(1'b1, 1'b0, 1'b1);
    i_host.frame_end();
    repeat (100) @(posedge clk_i);
    check("op count", n_ops, 7);
    i_host.frame_begin();
    i_host.byte1(8'hBB);
    i_host.addr2(24'h7F_FFFF);
    repeat (4) i_host.pair(1'b1, 1'b0, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      i_host.rbyte2(rd);
      check("dual read byte", rd, mdat(23'h7F_FFFF + 23'(k), 1'b0));
    end
    check("serial_lane_one_oe_o", d_oe1, 1);
    i_host.frame_end();
    check("serial_lane_zero_oe_o", d_oe0, 0);
    i_host.frame_begin();
    i_host.byte1(8'h88);
    i_host.byte1(8'h1F);
    i_host.byte1(8'h3C);
    i_host.rbyte1(rd);
    check("security byte", rd, 8'h7F);
    i_host.rbyte1(rd);
    check("security byte", rd, 8'h60);
    i_host.frame_end();
    results();
  end
endmodule
